/* logic/ats_pkg.sv */
package ats_pkg;
	localparam int NUM_CH = 3;
	localparam int NUM_HB = 4;
	localparam int CODE_W = 5;
	localparam int DELAY_W = 10;
	localparam int TIMER_W = 8;

	typedef logic [CODE_W-1:0] ats_code_type;
	typedef logic [DELAY_W-1:0] ats_delay_type;
	typedef logic [TIMER_W-1:0] ats_timer_type;

	localparam ats_code_type CODE_ZERO = 5'h00;
	localparam ats_code_type MIN_CHARGE_CODE = 5'h00;
	localparam ats_code_type STRONGEST_SINK_CODE = 5'h1F;
	localparam ats_code_type STEP_ONE = 5'h01;
	localparam ats_code_type STEP_TWO = 5'h02;
	localparam ats_delay_type DELAY_ZERO = 10'h000;
	localparam ats_delay_type DELAY_ONE = 10'h001;
	localparam ats_delay_type DELAY_MAX = 10'h3FF;
	localparam ats_timer_type TIMER_ZERO = 8'h00;
	localparam ats_timer_type TIMER_ONE = 8'h01;

	// Clock period and post-charge step time, both in picoseconds
	localparam int CLK_PERIOD_PS = 10000;
	localparam int POSTCHG_STEP_PS = 62500;
	// Post-charge step time in cycles: rounds down, never below one cycle
	localparam int POSTCHG_STEP_CYCLES = (POSTCHG_STEP_PS / CLK_PERIOD_PS) < 1 ? 1 : (POSTCHG_STEP_PS / CLK_PERIOD_PS);
	localparam ats_timer_type POSTCHG_RELOAD = TIMER_W'(POSTCHG_STEP_CYCLES - 1);

	// Duration in cycles for each value of a two-bit time field
	localparam ats_timer_type TIME_CYC_0 = 8'h04;
	localparam ats_timer_type TIME_CYC_1 = 8'h08;
	localparam ats_timer_type TIME_CYC_2 = 8'h10;
	localparam ats_timer_type TIME_CYC_3 = 8'h20;

	typedef enum logic [2:0] {PH_IDLE, PH_GUARD, PH_PRECHG, PH_CHARGE, PH_POSTCHG, PH_HOLD} ats_phase_type;
	typedef enum logic [1:0] {DIR_EQUAL, DIR_LONG, DIR_SHORT} ats_dir_type;

	typedef struct packed {
		logic [1:0] hb_sel;
		ats_code_type precharge_initial_value;
		ats_code_type max_drive_current;
		ats_code_type charge_current_setting;
		ats_code_type freewheel_drive_current;
		ats_code_type discharge_current_code;
		ats_delay_type turn_on_delay;
		logic [1:0] precharge_time_field;
		logic [1:0] predischarge_time_field;
		ats_timer_type guard_time;
	} ats_chan_cfg_type;

	typedef struct packed {
		logic [1:0] adaptive_control_select;
		logic adaptation_filter_enable;
		logic adaptation_step_size;
		logic postcharge_disable;
	} ats_gen_cfg_type;

	typedef struct packed {
		ats_code_type hs_code;
		logic hs_on;
		ats_code_type ls_code;
		logic ls_off;
	} ats_hb_drive_type;

	typedef struct packed {
		ats_phase_type phase;
		ats_timer_type timer;
		ats_delay_type delay_cnt;
		logic measuring;
		ats_delay_type meas_delay;
		ats_code_type hs_code;
		ats_code_type precharge_code;
		ats_dir_type dir_last;
		ats_dir_type dir_prev;
		logic result_new;
		logic pwm_prev;
	} ats_chan_state_type;

	typedef struct packed {
		ats_chan_state_type [NUM_CH-1:0] ch;
		ats_hb_drive_type [NUM_HB-1:0] hb;
		logic [NUM_CH-1:0] strong_sink;
		ats_timer_type [NUM_CH-1:0] predchg_cycles;
	} ats_state_type;

	typedef struct packed {
		logic [NUM_CH-1:0] meta;
		logic [NUM_CH-1:0] sync;
	} ats_sync_state_type;

	function automatic ats_timer_type ats_time_cycles(input logic [1:0] field);
		case (field)
			2'h0: return TIME_CYC_0;
			2'h1: return TIME_CYC_1;
			2'h2: return TIME_CYC_2;
			default: return TIME_CYC_3;
		endcase
	endfunction

	function automatic ats_code_type ats_min_code(input ats_code_type a, input ats_code_type b);
		return (a < b) ? a : b;
	endfunction
endpackage

/* logic/ats_sync.sv */
`timescale 1ns/10ps
module ats_sync (
	input wire logic clk_i, // Device clock
	input wire logic srst_i, // Synchronous reset, active high
	input wire logic [ats_pkg::NUM_CH-1:0] pwm_i, // Raw PWM inputs
	output logic [ats_pkg::NUM_CH-1:0] sync_o // Synchronized PWM
);
	ats_pkg::ats_sync_state_type st;
	ats_pkg::ats_sync_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.meta = pwm_i; // R13
		next_st.sync = st.meta; // R13
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sync_o = st.sync;

	a_sync_latency: assert property (@(posedge clk_i) disable iff (srst_i) // R13
		(!$past(srst_i) && !$past(srst_i, 2)) |-> (sync_o == $past(pwm_i, 2)))
		else $error("PWM sync latency is not two cycles");
endmodule

/* logic/ats_adapt.sv */
`timescale 1ns/10ps
module ats_adapt (
	input wire ats_pkg::ats_code_type code_i, // Present pre-charge code
	input wire ats_pkg::ats_code_type max_i, // Channel maximum drive code
	input wire ats_pkg::ats_dir_type dir_last_i, // Latest delay verdict
	input wire ats_pkg::ats_dir_type dir_prev_i, // Verdict before that
	input wire logic filter_i, // Two-cycle filter enable
	input wire logic step_size_i, // Two steps when high
	output ats_pkg::ats_code_type code_o // Adapted code
);
	logic up;
	logic down;
	ats_pkg::ats_code_type step;
	logic [ats_pkg::CODE_W:0] sum;
	logic [ats_pkg::CODE_W:0] floor_sum;
	ats_pkg::ats_code_type raw;

	always_comb begin
		up = filter_i ? (dir_last_i == ats_pkg::DIR_LONG && dir_prev_i == ats_pkg::DIR_LONG) // R12
			: (dir_last_i == ats_pkg::DIR_LONG); // R10
		down = filter_i ? (dir_last_i == ats_pkg::DIR_SHORT && dir_prev_i == ats_pkg::DIR_SHORT) // R12
			: (dir_last_i == ats_pkg::DIR_SHORT); // R10
		step = step_size_i ? ats_pkg::STEP_TWO : ats_pkg::STEP_ONE; // R11
		sum = {1'b0, code_i} + {1'b0, step};
		floor_sum = {1'b0, ats_pkg::MIN_CHARGE_CODE} + {1'b0, step};
		raw = code_i;
		if (up) begin
			raw = (sum > {1'b0, max_i}) ? max_i : sum[ats_pkg::CODE_W-1:0]; // R8
		end else if (down) begin
			raw = ({1'b0, code_i} < floor_sum) ? ats_pkg::MIN_CHARGE_CODE : ats_pkg::CODE_W'(code_i - step); // R8
		end
		// A lowered maximum still bounds a code stored earlier
		code_o = ats_pkg::ats_min_code(raw, max_i); // R8
	end
endmodule

/* logic/ats_top.sv */
`timescale 1ns/10ps
// Operation
// R1: PWM rise starts guard, low side off
// R2: After guard, adaptive pre-charge code for duration
// R3: Charge current until switch node passes high
// R4: Delay runs guard end to low threshold
// R5: Post-charge raises code every 62.5 ns; code steps every 6 cycles (60 ns)
// R6: Post-charge skipped when disable bit set
// R7: Adapt only in modes (1,0), (1,1)
// R8: Pre-charge code clamped minimum to maximum
// R9: Enable command loads min(initial, maximum)
// R10: Unfiltered: longer delay raises, shorter lowers
// R11: Step size one or two steps
// R12: Filtered: adjust only on two agreeing cycles
// R13: PWM inputs synchronized before the sequencer
// R14: Measured delay readable per channel
// R15: Two-bit pre-charge, pre-discharge time fields
// R16: Discharge code 31 is strongest sink
// R17: Three channels, any of four bridges
// R18: Delay counted and compared in cycles
module ats_top (
	input wire logic REF_CLK_I, // Device clock, 100 MHz
	input wire logic SRST_I, // Synchronous reset, active high
	input wire logic [ats_pkg::NUM_CH-1:0] PWM_I, // External PWM inputs
	input wire logic [ats_pkg::NUM_CH-1:0] PWM_EN_I, // PWM channel enable levels
	input wire logic [ats_pkg::NUM_CH-1:0] PWM_EN_WR_I, // Serial write of enable, pulse
	input wire ats_pkg::ats_chan_cfg_type [ats_pkg::NUM_CH-1:0] CFG_I, // Per-channel configuration
	input wire ats_pkg::ats_gen_cfg_type GEN_I, // Shared configuration
	input wire logic [ats_pkg::NUM_HB-1:0] SH_HIGH_I, // Switch node above high threshold
	input wire logic [ats_pkg::NUM_HB-1:0] SH_LOW_I, // Switch node above low threshold
	output ats_pkg::ats_hb_drive_type [ats_pkg::NUM_HB-1:0] HB_DRIVE_O, // Gate drive per bridge
	output ats_pkg::ats_delay_type [ats_pkg::NUM_CH-1:0] MEAS_DELAY_O, // Measured delay status
	output ats_pkg::ats_code_type [ats_pkg::NUM_CH-1:0] PRECHG_CODE_O, // Adaptive pre-charge code
	output ats_pkg::ats_timer_type [ats_pkg::NUM_CH-1:0] PREDCHG_CYCLES_O, // Pre-discharge duration
	output logic [ats_pkg::NUM_CH-1:0] STRONG_SINK_O // Hard turn-off selected
);
	ats_pkg::ats_state_type st;
	ats_pkg::ats_state_type next_st;
	logic [ats_pkg::NUM_CH-1:0] pwm_sync;
	logic [ats_pkg::NUM_CH-1:0] rise;
	logic [ats_pkg::NUM_CH-1:0] run;
	logic [ats_pkg::NUM_CH-1:0] load_init;
	logic [ats_pkg::NUM_CH-1:0] sh_low_m;
	logic [ats_pkg::NUM_CH-1:0] sh_high_m;
	ats_pkg::ats_code_type [ats_pkg::NUM_CH-1:0] adapt_code;
	ats_pkg::ats_code_type [ats_pkg::NUM_CH-1:0] init_code;
	ats_pkg::ats_dir_type [ats_pkg::NUM_CH-1:0] dir_new;
	logic adaptive;

	ats_sync u_sync (
		.clk_i(REF_CLK_I),
		.srst_i(SRST_I),
		.pwm_i(PWM_I),
		.sync_o(pwm_sync)
	);

	assign adaptive = GEN_I.adaptive_control_select[1]; // R7

	genvar gc;
	generate
		for (gc = 0; gc < ats_pkg::NUM_CH; gc++) begin : g_ch
			assign rise[gc] = pwm_sync[gc] & ~st.ch[gc].pwm_prev; // R1
			assign run[gc] = pwm_sync[gc] & PWM_EN_I[gc];
			assign load_init[gc] = PWM_EN_WR_I[gc] & PWM_EN_I[gc]; // R9
			assign sh_low_m[gc] = SH_LOW_I[CFG_I[gc].hb_sel]; // R17
			assign sh_high_m[gc] = SH_HIGH_I[CFG_I[gc].hb_sel]; // R17
			assign init_code[gc] = ats_pkg::ats_min_code(CFG_I[gc].precharge_initial_value,
				CFG_I[gc].max_drive_current); // R9
			// Verdict compares whole cycles against the target in the same unit
			assign dir_new[gc] = (st.ch[gc].delay_cnt > CFG_I[gc].turn_on_delay) ? ats_pkg::DIR_LONG // R18
				: (st.ch[gc].delay_cnt < CFG_I[gc].turn_on_delay) ? ats_pkg::DIR_SHORT : ats_pkg::DIR_EQUAL;

			ats_adapt u_adapt (
				.code_i(st.ch[gc].precharge_code),
				.max_i(CFG_I[gc].max_drive_current),
				.dir_last_i(st.ch[gc].dir_last),
				.dir_prev_i(st.ch[gc].dir_prev),
				.filter_i(GEN_I.adaptation_filter_enable),
				.step_size_i(GEN_I.adaptation_step_size),
				.code_o(adapt_code[gc])
			);
		end
	endgenerate

	always_comb begin
		next_st = st;
		for (int c = 0; c < ats_pkg::NUM_CH; c++) begin
			next_st.ch[c].pwm_prev = pwm_sync[c];
			next_st.strong_sink[c] = CFG_I[c].discharge_current_code == ats_pkg::STRONGEST_SINK_CODE; // R16
			next_st.predchg_cycles[c] = ats_pkg::ats_time_cycles(CFG_I[c].predischarge_time_field); // R15

			if (st.ch[c].measuring) begin
				// High threshold also stops the count in case the low crossing was missed
				if (sh_low_m[c] || sh_high_m[c]) begin
					next_st.ch[c].measuring = 1'b0; // R4
					next_st.ch[c].meas_delay = st.ch[c].delay_cnt; // R14
					next_st.ch[c].dir_prev = st.ch[c].dir_last; // R12
					next_st.ch[c].dir_last = dir_new[c]; // R10
					next_st.ch[c].result_new = 1'b1;
				end else if (st.ch[c].delay_cnt != ats_pkg::DELAY_MAX) begin
					next_st.ch[c].delay_cnt = st.ch[c].delay_cnt + ats_pkg::DELAY_ONE; // R18
				end
			end

			case (st.ch[c].phase)
				ats_pkg::PH_IDLE: begin
					if (rise[c] && PWM_EN_I[c]) begin
						next_st.ch[c].phase = ats_pkg::PH_GUARD; // R1
						next_st.ch[c].timer = CFG_I[c].guard_time; // R1
					end
				end
				ats_pkg::PH_GUARD: begin
					if (st.ch[c].timer == ats_pkg::TIMER_ZERO) begin
						next_st.ch[c].measuring = 1'b1; // R4
						next_st.ch[c].delay_cnt = ats_pkg::DELAY_ZERO; // R4
						if (adaptive) begin
							next_st.ch[c].phase = ats_pkg::PH_PRECHG; // R2
							next_st.ch[c].timer = ats_pkg::TIMER_W'(ats_pkg::ats_time_cycles(
								CFG_I[c].precharge_time_field) - ats_pkg::TIMER_ONE); // R15
							if (st.ch[c].result_new) begin
								next_st.ch[c].precharge_code = adapt_code[c]; // R7
								next_st.ch[c].result_new = 1'b0;
							end
							next_st.ch[c].hs_code = ats_pkg::ats_min_code(next_st.ch[c].precharge_code,
								CFG_I[c].max_drive_current); // R8
						end else begin
							// Non-adaptive modes have no pre-charge phase
							next_st.ch[c].phase = ats_pkg::PH_CHARGE;
							next_st.ch[c].hs_code = CFG_I[c].charge_current_setting; // R3
						end
					end else begin
						next_st.ch[c].timer = st.ch[c].timer - ats_pkg::TIMER_ONE;
					end
				end
				ats_pkg::PH_PRECHG: begin
					if (st.ch[c].timer == ats_pkg::TIMER_ZERO) begin
						next_st.ch[c].phase = ats_pkg::PH_CHARGE; // R3
						next_st.ch[c].hs_code = CFG_I[c].charge_current_setting; // R3
					end else begin
						next_st.ch[c].timer = st.ch[c].timer - ats_pkg::TIMER_ONE; // R2
					end
				end
				ats_pkg::PH_CHARGE: begin
					if (sh_high_m[c]) begin
						if (GEN_I.postcharge_disable || st.ch[c].hs_code >= CFG_I[c].max_drive_current) begin
							next_st.ch[c].phase = ats_pkg::PH_HOLD; // R6
						end else begin
							next_st.ch[c].phase = ats_pkg::PH_POSTCHG; // R5
							next_st.ch[c].timer = ats_pkg::POSTCHG_RELOAD; // R5
						end
					end
				end
				ats_pkg::PH_POSTCHG: begin
					if (st.ch[c].timer != ats_pkg::TIMER_ZERO) begin
						next_st.ch[c].timer = st.ch[c].timer - ats_pkg::TIMER_ONE;
					end else if (st.ch[c].hs_code >= CFG_I[c].max_drive_current) begin
						next_st.ch[c].phase = ats_pkg::PH_HOLD;
					end else begin
						next_st.ch[c].hs_code = st.ch[c].hs_code + ats_pkg::STEP_ONE; // R5
						next_st.ch[c].timer = ats_pkg::POSTCHG_RELOAD; // R5
						if (next_st.ch[c].hs_code >= CFG_I[c].max_drive_current) begin
							next_st.ch[c].phase = ats_pkg::PH_HOLD;
						end
					end
				end
				ats_pkg::PH_HOLD: begin
					next_st.ch[c].phase = ats_pkg::PH_HOLD;
				end
				default: begin
					next_st.ch[c].phase = ats_pkg::PH_IDLE;
				end
			endcase

			// Turn-off is handled elsewhere; a falling PWM just ends the turn-on
			if (!run[c]) begin
				next_st.ch[c].phase = ats_pkg::PH_IDLE;
				next_st.ch[c].measuring = 1'b0;
				next_st.ch[c].timer = ats_pkg::TIMER_ZERO;
				next_st.ch[c].hs_code = ats_pkg::CODE_ZERO;
			end

			// An enable command outranks a pending adaptation
			if (load_init[c]) begin
				next_st.ch[c].precharge_code = init_code[c]; // R9
				next_st.ch[c].dir_last = ats_pkg::DIR_EQUAL;
				next_st.ch[c].dir_prev = ats_pkg::DIR_EQUAL;
				next_st.ch[c].result_new = 1'b0;
			end
		end

		for (int h = 0; h < ats_pkg::NUM_HB; h++) begin
			next_st.hb[h] = '0;
			// Walk downward so the lowest channel wins a shared bridge
			for (int c = ats_pkg::NUM_CH - 1; c >= 0; c--) begin
				if (CFG_I[c].hb_sel == 2'(h) && PWM_EN_I[c]) begin
					next_st.hb[h].hs_on = next_st.ch[c].phase inside {ats_pkg::PH_PRECHG, ats_pkg::PH_CHARGE,
						ats_pkg::PH_POSTCHG, ats_pkg::PH_HOLD}; // R1
					next_st.hb[h].hs_code = next_st.ch[c].hs_code; // R17
					next_st.hb[h].ls_off = next_st.ch[c].phase != ats_pkg::PH_IDLE; // R1
					next_st.hb[h].ls_code = (next_st.ch[c].phase == ats_pkg::PH_GUARD)
						? CFG_I[c].freewheel_drive_current : ats_pkg::CODE_ZERO; // R1
				end
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SRST_I) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign HB_DRIVE_O = st.hb;
	assign STRONG_SINK_O = st.strong_sink;
	assign PREDCHG_CYCLES_O = st.predchg_cycles;

	generate
		for (gc = 0; gc < ats_pkg::NUM_CH; gc++) begin : g_out
			assign MEAS_DELAY_O[gc] = st.ch[gc].meas_delay; // R14
			assign PRECHG_CODE_O[gc] = st.ch[gc].precharge_code;

			sequence s_charge_done;
				st.ch[gc].phase == ats_pkg::PH_CHARGE && sh_high_m[gc] && run[gc];
			endsequence

			sequence s_adapt_point;
				st.ch[gc].phase == ats_pkg::PH_GUARD && st.ch[gc].timer == ats_pkg::TIMER_ZERO && run[gc]
					&& adaptive && st.ch[gc].result_new && !load_init[gc];
			endsequence

			a_guard_on_rise: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R1
				(st.ch[gc].phase == ats_pkg::PH_IDLE && rise[gc] && PWM_EN_I[gc])
				|=> (st.ch[gc].phase == ats_pkg::PH_GUARD && st.ch[gc].timer == $past(CFG_I[gc].guard_time)))
				else $error("Guard did not start on PWM rise");

			a_precharge_code: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R2
				(st.ch[gc].phase == ats_pkg::PH_GUARD && st.ch[gc].timer == ats_pkg::TIMER_ZERO && run[gc]
					&& adaptive && !st.ch[gc].result_new)
				|=> (st.ch[gc].phase == ats_pkg::PH_PRECHG && st.ch[gc].hs_code
					== ats_pkg::ats_min_code($past(st.ch[gc].precharge_code), $past(CFG_I[gc].max_drive_current))))
				else $error("Pre-charge did not apply the stored code");

			a_charge_stay: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R3
				(st.ch[gc].phase == ats_pkg::PH_CHARGE && !sh_high_m[gc] && run[gc])
				|=> (st.ch[gc].phase == ats_pkg::PH_CHARGE))
				else $error("Charge phase left before high threshold");

			a_delay_capture: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R4
				(st.ch[gc].measuring && sh_low_m[gc])
				|=> (!st.ch[gc].measuring && MEAS_DELAY_O[gc] == $past(st.ch[gc].delay_cnt)))
				else $error("Measured delay not captured at low threshold");

			a_post_step: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R5
				(st.ch[gc].phase == ats_pkg::PH_POSTCHG && st.ch[gc].timer == ats_pkg::TIMER_ZERO && run[gc]
					&& st.ch[gc].hs_code < CFG_I[gc].max_drive_current)
				|=> (st.ch[gc].hs_code == ats_pkg::CODE_W'($past(st.ch[gc].hs_code) + ats_pkg::STEP_ONE)))
				else $error("Post-charge step missing");

			a_post_disable: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R6
				(s_charge_done and GEN_I.postcharge_disable) |=> (st.ch[gc].phase == ats_pkg::PH_HOLD))
				else $error("Post-charge ran while disabled");

			a_fixed_mode: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R7
				(!adaptive && !load_init[gc]) |=> $stable(st.ch[gc].precharge_code))
				else $error("Code adapted in a non-adaptive mode");

			a_code_bounds: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R8
				(st.ch[gc].phase == ats_pkg::PH_PRECHG && $stable(CFG_I[gc].max_drive_current))
				|-> (st.ch[gc].hs_code <= CFG_I[gc].max_drive_current))
				else $error("Pre-charge code above maximum");

			a_init_load: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R9
				load_init[gc] |=> (st.ch[gc].precharge_code == ats_pkg::ats_min_code(
					$past(CFG_I[gc].precharge_initial_value), $past(CFG_I[gc].max_drive_current))))
				else $error("Enable command did not load initial code");

			a_adapt_up: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R10
				(s_adapt_point and (!GEN_I.adaptation_filter_enable && !GEN_I.adaptation_step_size
					&& st.ch[gc].dir_last == ats_pkg::DIR_LONG
					&& st.ch[gc].precharge_code < CFG_I[gc].max_drive_current))
				|=> (st.ch[gc].precharge_code == ats_pkg::CODE_W'($past(st.ch[gc].precharge_code) + ats_pkg::STEP_ONE)))
				else $error("Long delay did not raise the code by one");

			a_adapt_two: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R11
				(s_adapt_point and (!GEN_I.adaptation_filter_enable && GEN_I.adaptation_step_size
					&& st.ch[gc].dir_last == ats_pkg::DIR_SHORT && st.ch[gc].precharge_code >= ats_pkg::STEP_TWO
					&& st.ch[gc].precharge_code <= CFG_I[gc].max_drive_current))
				|=> (st.ch[gc].precharge_code == ats_pkg::CODE_W'($past(st.ch[gc].precharge_code) - ats_pkg::STEP_TWO)))
				else $error("Short delay did not lower the code by two");

			a_filter_hold: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R12
				(s_adapt_point and (GEN_I.adaptation_filter_enable && st.ch[gc].dir_last != st.ch[gc].dir_prev
					&& st.ch[gc].precharge_code <= CFG_I[gc].max_drive_current))
				|=> $stable(st.ch[gc].precharge_code))
				else $error("Filtered code changed on disagreeing cycles");

			a_strong_sink: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R16
				(CFG_I[gc].discharge_current_code == ats_pkg::STRONGEST_SINK_CODE) |=> STRONG_SINK_O[gc])
				else $error("Strongest sink not flagged");
		end
	endgenerate

	// Channel one owns bridge two only while channel zero does not claim it
	a_route_first: assert property (@(posedge REF_CLK_I) disable iff (SRST_I) // R17
		(PWM_EN_I[1] && CFG_I[1].hb_sel == 2'h2 && !(PWM_EN_I[0] && CFG_I[0].hb_sel == 2'h2))
		|=> (HB_DRIVE_O[2].hs_code == st.ch[1].hs_code && HB_DRIVE_O[2].ls_off == (st.ch[1].phase != ats_pkg::PH_IDLE)))
		else $error("Channel not routed to selected bridge");
endmodule

/* test/ats_switch_model.sv */
`timescale 1ns/10ps
module ats_switch_model (
	input wire logic clk_i, // Device clock
	input wire logic srst_i, // Synchronous reset, active high
	input wire ats_pkg::ats_hb_drive_type [ats_pkg::NUM_HB-1:0] hb_i, // Gate drive per bridge
	input wire ats_pkg::ats_delay_type dly_i, // Cycles from turn-on to low threshold
	output logic [ats_pkg::NUM_HB-1:0] sh_high_o, // Node above high threshold
	output logic [ats_pkg::NUM_HB-1:0] sh_low_o // Node above low threshold
);
	ats_pkg::ats_delay_type cnt [ats_pkg::NUM_HB];
	// Node drops below both thresholds as soon as the high side lets go
	always_ff @(posedge clk_i) begin
		for (int b = 0; b < ats_pkg::NUM_HB; b++) begin
			cnt[b] <= (srst_i || !hb_i[b].hs_on) ? ats_pkg::DELAY_ZERO : cnt[b] + ats_pkg::DELAY_ONE;
		end
	end
	// High threshold two cycles after low, so the low crossing is always seen first
	always_comb begin
		for (int b = 0; b < ats_pkg::NUM_HB; b++) begin
			sh_low_o[b] = hb_i[b].hs_on && (cnt[b] >= dly_i);
			sh_high_o[b] = hb_i[b].hs_on && (cnt[b] >= dly_i + 10'h002);
		end
	end
endmodule

/* test/ats_top_bench.sv */
`timescale 1ns/10ps
module ats_top_bench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] pwm = 3'h0;
	logic [2:0] en = 3'h7;
	logic [2:0] en_wr = 3'h0;
	ats_pkg::ats_chan_cfg_type [2:0] cfg;
	ats_pkg::ats_gen_cfg_type gen;
	ats_pkg::ats_delay_type dly = 10'h000;
	logic [3:0] sh_high;
	logic [3:0] sh_low;
	ats_pkg::ats_hb_drive_type [3:0] hb;
	ats_pkg::ats_delay_type [2:0] meas;
	ats_pkg::ats_code_type [2:0] code;
	ats_pkg::ats_timer_type [2:0] predchg;
	logic [2:0] sink;
	ats_pkg::ats_hb_drive_type tr [120];
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	ats_top dut (.REF_CLK_I(clk), .SRST_I(srst), .PWM_I(pwm), .PWM_EN_I(en), .PWM_EN_WR_I(en_wr), .CFG_I(cfg),
		.GEN_I(gen), .SH_HIGH_I(sh_high), .SH_LOW_I(sh_low), .HB_DRIVE_O(hb), .MEAS_DELAY_O(meas),
		.PRECHG_CODE_O(code), .PREDCHG_CYCLES_O(predchg), .STRONG_SINK_O(sink));
	ats_switch_model far (.clk_i(clk), .srst_i(srst), .hb_i(hb), .dly_i(dly), .sh_high_o(sh_high), .sh_low_o(sh_low));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Guard cycles when g is set, else cycles with the high side on at code k
	function automatic int count(input logic g, input ats_pkg::ats_code_type k);
		int n = 0;
		for (int i = 0; i < 120; i++) begin
			if (g ? (tr[i].ls_off === 1'b1 && tr[i].hs_on === 1'b0) : (tr[i].hs_on === 1'b1 && tr[i].hs_code === k)) begin
				n++;
			end
		end
		return n;
	endfunction
	// tr[i] holds the drive after the i-th edge following the raw PWM rise
	task automatic pulse(input int c, input int b, input ats_pkg::ats_delay_type d);
		@(posedge clk);
		pwm[c] <= 1'b1;
		dly <= d;
		for (int i = 0; i < 120; i++) begin
			@(negedge clk);
			tr[i] = hb[b];
		end
		@(posedge clk);
		pwm[c] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic en_load(input int c, input ats_pkg::ats_code_type v);
		@(posedge clk);
		cfg[c].precharge_initial_value <= v;
		@(posedge clk);
		en_wr[c] <= 1'b1;
		@(posedge clk);
		en_wr[c] <= 1'b0;
		@(negedge clk);
	endtask
	task automatic t_reset();
		chk("reset drive", 32'h0, {hb[1], hb[0]});
		chk("reset code", 32'h0, code);
		chk("reset meas", 32'h0, meas[1:0]);
		$display("t_reset done");
	endtask
	task automatic t_load();
		en_load(0, 5'h14);
		chk("load clamp", 32'h10, code[0]);
		en_load(0, 5'h05);
		chk("load init", 32'h05, code[0]);
		$display("t_load done");
	endtask
	task automatic t_seq();
		pulse(0, 0, 10'h00A);
		chk("sync", 32'h0, tr[2].ls_off);
		chk("guard", 32'h1, tr[3].ls_off);
		chk("fw code", 32'h07, tr[3].ls_code);
		chk("guard len", 32'h3, count(1'b1, 5'h00));
		chk("prechg len", 32'h4, count(1'b0, 5'h05));
		chk("charge len", 32'hF, count(1'b0, 5'h0A));
		chk("post step", 32'h6, count(1'b0, 5'h0B));
		chk("post end", 32'h10, tr[119].hs_code);
		chk("meas", 32'h0A, meas[0]);
		chk("equal", 32'h05, code[0]);
		$display("t_seq done");
	endtask
	task automatic t_adapt();
		pulse(0, 0, 10'h014);
		pulse(0, 0, 10'h003);
		chk("long raises", 32'h06, code[0]);
		chk("raised used", 32'h4, count(1'b0, 5'h06));
		@(posedge clk);
		gen.adaptation_step_size <= 1'b1;
		pulse(0, 0, 10'h014);
		chk("short lowers", 32'h04, code[0]);
		en_load(0, 5'h0F);
		pulse(0, 0, 10'h014);
		pulse(0, 0, 10'h014);
		chk("clamp max", 32'h10, code[0]);
		en_load(0, 5'h01);
		pulse(0, 0, 10'h003);
		pulse(0, 0, 10'h003);
		chk("clamp min", 32'h00, code[0]);
		$display("t_adapt done");
	endtask
	task automatic t_filter();
		ats_pkg::ats_delay_type d [5] = '{10'h014, 10'h003, 10'h014, 10'h014, 10'h00A};
		@(posedge clk);
		gen.adaptation_step_size <= 1'b0;
		gen.adaptation_filter_enable <= 1'b1;
		en_load(0, 5'h05);
		for (int i = 0; i < 5; i++) begin
			pulse(0, 0, d[i]);
			chk("filter", (i == 4) ? 32'h06 : 32'h05, code[0]);
		end
		$display("t_filter done");
	endtask
	task automatic t_modes();
		@(posedge clk);
		gen.adaptation_filter_enable <= 1'b0;
		en_load(0, 5'h05);
		for (int a = 0; a < 2; a++) begin
			@(posedge clk);
			gen.adaptive_control_select <= 2'(a);
			pulse(0, 0, 10'h014);
			chk("no prechg", 32'h0, count(1'b0, 5'h05));
			chk("no adapt", 32'h05, code[0]);
		end
		@(posedge clk);
		gen.adaptive_control_select <= 2'h3;
		en_load(0, 5'h05);
		pulse(0, 0, 10'h014);
		pulse(0, 0, 10'h014);
		chk("mode 3", 32'h4, count(1'b0, 5'h06));
		@(posedge clk);
		gen.postcharge_disable <= 1'b1;
		pulse(0, 0, 10'h00A);
		chk("no post", 32'h0, count(1'b0, 5'h0B));
		@(posedge clk);
		gen.postcharge_disable <= 1'b0;
		gen.adaptive_control_select <= 2'h2;
		$display("t_modes done");
	endtask
	task automatic t_fields();
		en_load(0, 5'h05);
		for (int f = 0; f < 4; f++) begin
			@(posedge clk);
			cfg[0].precharge_time_field <= 2'(f);
			cfg[0].predischarge_time_field <= 2'(f);
			cfg[0].discharge_current_code <= 5'h1C + 5'(f);
			cfg[0].turn_on_delay <= 10'h028;
			pulse(0, 0, 10'h028);
			chk("prechg time", 32'h4 << f, count(1'b0, 5'h05));
			chk("predchg time", 32'h4 << f, predchg[0]);
			chk("sink", f == 3, sink[0]);
		end
		$display("t_fields done");
	endtask
	task automatic t_route();
		en_load(1, 5'h05);
		pulse(1, 2, 10'h00A);
		chk("route guard", 32'h3, count(1'b1, 5'h00));
		chk("route prechg", 32'h4, count(1'b0, 5'h05));
		chk("route meas", 32'h0A, meas[1]);
		$display("t_route done");
	endtask
	initial begin
		cfg = '0;
		for (int c = 0; c < 3; c++) begin
			cfg[c].hb_sel = 2'(2 * c);
			cfg[c].precharge_initial_value = 5'h05;
			cfg[c].max_drive_current = 5'h10;
			cfg[c].charge_current_setting = 5'h0A;
			cfg[c].freewheel_drive_current = 5'h07;
			cfg[c].turn_on_delay = 10'h00A;
			cfg[c].guard_time = 8'h02;
		end
		gen = '0;
		gen.adaptive_control_select = 2'h2;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_load();
		t_seq();
		t_adapt();
		t_filter();
		t_modes();
		t_fields();
		t_route();
		give_verdict();
	end
endmodule
